// file: logic/pmrs_master_read.sv
/*
  PCI master read sequencer: single-cycle and burst reads, wait propagation,
  transaction status, and a small AXI4-Lite register slave.
  Assumes all inputs synchronous to clk; pin resolution is done outside.
*/
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module pmrs_master_read
  import pmrs_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // local side
  input  wire logic              local_master_request_n,
  input  wire logic [31:0]       local_addr_data_in,
  input  wire logic [3:0]        local_cmd_byte_en_n,
  input  wire logic              local_last_transfer_n,
  input  wire logic              local_wait_request_n,
  output logic                   local_data_ack_n,
  output logic [31:0]            local_read_data_out,
  output logic [7:0]             txn_status_out,
  // pci arbitration
  output logic                   reqn,
  input  wire logic              gntn,
  // pci address/data and command
  input  wire logic [31:0]       ad_in,
  output logic [31:0]            ad_out,
  output logic                   ad_oe,
  output logic [3:0]             cben_out,
  output logic                   cben_oe,
  // pci control
  input  wire logic              framen_in,
  output logic                   framen_out,
  output logic                   framen_oe,
  input  wire logic              irdyn_in,
  output logic                   irdyn_out,
  output logic                   irdyn_oe,
  input  wire logic              trdyn,
  input  wire logic              devseln,
  // axi4-lite slave
  input  wire logic [AXI_AW-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [AXI_AW-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready
);
  typedef struct packed {
    pmrs_state_e       st;
    logic              reqn;
    logic              ad_oe;
    logic [3:0]        cbe;
    logic              cbe_oe;
    logic              frame;
    logic              frame_oe;
    logic              irdy;
    logic              irdy_oe;
    logic              ack_n;
    logic [7:0]        tsr;
    logic              last_seen;
    logic              final_req;
    logic              pend;
    logic [3:0]        cmd;
    logic              en;
    logic [CNT_W-1:0]  cnt;
    logic              aw_h;
    logic [AXI_AW-1:0] aw_a;
    logic              w_h;
    logic [31:0]       w_d;
    logic [3:0]        w_s;
    logic              awrdy;
    logic              wrdy;
    logic              bvld;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvld;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } pmrs_regs_s;

  pmrs_regs_s  r_r;
  pmrs_regs_s  r_nxt;
  logic        busy;
  logic        done;
  logic        lastp;
  logic        single;
  logic        fin;
  logic        ack_go;
  logic        addr_load;
  logic [31:0] addr_q;
  logic [31:0] hold_q;
  logic [31:0] rd_d;
  logic [31:0] stat_word;

  assign busy = !local_wait_request_n;
  assign done = (r_r.st == ST_DAT) && !r_r.irdy && !trdyn && !devseln;
  // only the first clock of last counts
  assign lastp = !local_last_transfer_n && !r_r.last_seen;
  assign addr_load = (r_r.st == ST_IDLE) && !local_master_request_n && r_r.en;
  // a word taken while the local side is busy waits in the hold register
  assign ack_go = !busy && (done || r_r.pend);
  assign rd_d = r_r.pend ? hold_q : ad_in;

  always_comb begin
    stat_word = '0;
    stat_word[7:0] = r_r.tsr;
    stat_word[STAT_ST_LSB +: 6] = r_r.st;
    stat_word[STAT_PEND] = r_r.pend;
  end

  always_comb begin
    r_nxt = r_r;
    single = 1'b0;
    fin = 1'b0;
    // word goes out the clock after completion unless busy holds it back
    r_nxt.pend = busy && (r_r.pend || done);
    r_nxt.ack_n = !ack_go;
    r_nxt.tsr[TSR_DONE] = done;
    if (done) begin
      r_nxt.cnt = r_r.cnt + CNT_W'(1);
    end
    case (r_r.st)
      ST_IDLE: begin
        r_nxt.last_seen = 1'b0;
        if (addr_load) begin
          r_nxt.st = ST_REQ;
          r_nxt.cmd = local_cmd_byte_en_n;
          r_nxt.reqn = 1'b0;
          r_nxt.tsr[TSR_REQ] = 1'b1;
          r_nxt.last_seen = !local_last_transfer_n;
        end
      end
      ST_REQ: begin
        if (lastp) begin
          r_nxt.last_seen = 1'b1;
        end
        // grant only counts while the bus is idle
        if (!gntn && framen_in && irdyn_in) begin
          r_nxt.st = ST_DRV;
          r_nxt.ad_oe = 1'b1;
          r_nxt.cbe = r_r.cmd;
          r_nxt.cbe_oe = 1'b1;
          r_nxt.frame = 1'b1;
          r_nxt.frame_oe = 1'b1;
          r_nxt.irdy = 1'b1;
          r_nxt.irdy_oe = 1'b1;
          r_nxt.tsr[TSR_GNT] = 1'b1;
        end
      end
      ST_DRV: begin
        if (lastp) begin
          r_nxt.last_seen = 1'b1;
        end
        r_nxt.st = ST_ADR;
        r_nxt.frame = 1'b0;
        r_nxt.reqn = 1'b1;
      end
      ST_ADR: begin
        // memory read flavours share one path
        single = (r_r.cmd == CMD_IO_RD) || (r_r.cmd == CMD_CFG_RD)
                 || r_r.last_seen || !local_last_transfer_n;
        r_nxt.st = ST_DAT;
        r_nxt.ad_oe = 1'b0;
        r_nxt.irdy = 1'b0;
        r_nxt.frame = single;
        r_nxt.last_seen = single;
        r_nxt.final_req = 1'b0;
        r_nxt.cbe = single ? local_cmd_byte_en_n : BE_ALL_N;
        r_nxt.tsr[TSR_XFER] = 1'b1;
      end
      ST_DAT: begin
        if (done && r_r.frame) begin
          r_nxt.st = ST_TA1;
          r_nxt.irdy = 1'b1;
          r_nxt.cbe_oe = 1'b0;
          r_nxt.frame_oe = 1'b0;
        end else begin
          // irdyn only rises after a completed phase or while already waiting
          r_nxt.irdy = r_nxt.pend || (r_r.irdy && busy);
          fin = r_r.final_req || lastp;
          if (lastp) begin
            r_nxt.last_seen = 1'b1;
          end
          // framen may only rise together with an asserted irdyn
          if (fin && !r_nxt.irdy) begin
            r_nxt.frame = 1'b1;
            r_nxt.final_req = 1'b0;
          end else begin
            r_nxt.final_req = fin;
          end
        end
      end
      ST_TA1: begin
        r_nxt.st = ST_IDLE;
        r_nxt.irdy_oe = 1'b0;
        r_nxt.tsr = TSR_RST;
      end
      default: begin
        r_nxt.st = ST_IDLE;
        r_nxt.ad_oe = 1'b0;
        r_nxt.cbe_oe = 1'b0;
        r_nxt.frame_oe = 1'b0;
        r_nxt.irdy_oe = 1'b0;
        r_nxt.reqn = 1'b1;
        r_nxt.tsr = TSR_RST;
      end
    endcase

    // axi write channels, taken in either order
    if (s_awvalid && r_r.awrdy) begin
      r_nxt.aw_h = 1'b1;
      r_nxt.aw_a = s_awaddr;
    end
    if (s_wvalid && r_r.wrdy) begin
      r_nxt.w_h = 1'b1;
      r_nxt.w_d = s_wdata;
      r_nxt.w_s = s_wstrb;
    end
    if (r_r.bvld && s_bready) begin
      r_nxt.bvld = 1'b0;
    end
    if (r_r.aw_h && r_r.w_h && !r_r.bvld) begin
      r_nxt.aw_h = 1'b0;
      r_nxt.w_h = 1'b0;
      r_nxt.bvld = 1'b1;
      r_nxt.bresp = RESP_OKAY;
      case (r_r.aw_a)
        OFS_CTRL: begin
          if (r_r.w_s[0]) begin
            r_nxt.en = r_r.w_d[CTRL_EN];
          end
        end
        OFS_STAT: begin
          r_nxt.bresp = RESP_OKAY;
        end
        OFS_PHASE: begin
          // a phase finishing in the clearing clock is still counted
          r_nxt.cnt = CNT_W'(done);
        end
        default: begin
          r_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    r_nxt.awrdy = !r_nxt.aw_h && !r_nxt.bvld;
    r_nxt.wrdy = !r_nxt.w_h && !r_nxt.bvld;

    // axi read channel
    if (r_r.rvld && s_rready) begin
      r_nxt.rvld = 1'b0;
    end
    if (s_arvalid && r_r.arrdy) begin
      r_nxt.rvld = 1'b1;
      r_nxt.rresp = RESP_OKAY;
      case (s_araddr)
        OFS_CTRL: begin
          r_nxt.rdata = 32'({r_r.en});
        end
        OFS_STAT: begin
          r_nxt.rdata = stat_word;
        end
        OFS_PHASE: begin
          r_nxt.rdata = 32'(r_r.cnt);
        end
        default: begin
          r_nxt.rdata = 32'h0;
          r_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    r_nxt.arrdy = !r_nxt.rvld;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_r <= '0;
      r_r.st <= ST_IDLE;
      r_r.reqn <= 1'b1;
      r_r.frame <= 1'b1;
      r_r.irdy <= 1'b1;
      r_r.ack_n <= 1'b1;
      r_r.tsr <= TSR_RST;
      r_r.en <= CTRL_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  pmrs_word_reg #(
    .W(32)
  ) u_addr (
    .clk  (clk),
    .nrst (nrst),
    .load (addr_load),
    .d    (local_addr_data_in),
    .q    (addr_q)
  );

  pmrs_word_reg #(
    .W(32)
  ) u_hold (
    .clk  (clk),
    .nrst (nrst),
    .load (done && busy),
    .d    (ad_in),
    .q    (hold_q)
  );

  pmrs_word_reg #(
    .W(32)
  ) u_rdata (
    .clk  (clk),
    .nrst (nrst),
    .load (ack_go),
    .d    (rd_d),
    .q    (local_read_data_out)
  );

  // no retry, disconnect or master abort handling: a target that never
  // answers holds the sequencer in the data phase
  assign local_data_ack_n = r_r.ack_n;
  assign txn_status_out   = r_r.tsr;
  assign reqn             = r_r.reqn;
  assign ad_out           = addr_q;
  assign ad_oe            = r_r.ad_oe;
  assign cben_out         = r_r.cbe;
  assign cben_oe          = r_r.cbe_oe;
  assign framen_out       = r_r.frame;
  assign framen_oe        = r_r.frame_oe;
  assign irdyn_out        = r_r.irdy;
  assign irdyn_oe         = r_r.irdy_oe;
  assign s_awready        = r_r.awrdy;
  assign s_wready         = r_r.wrdy;
  assign s_bvalid         = r_r.bvld;
  assign s_bresp          = r_r.bresp;
  assign s_arready        = r_r.arrdy;
  assign s_rvalid         = r_r.rvld;
  assign s_rdata          = r_r.rdata;
  assign s_rresp          = r_r.rresp;
endmodule

// file: inc/pmrs_pkg.sv
/*
  Constants, encodings and the state type of the PCI master read sequencer.
  Assumes a 32-bit PCI bus, a local-side application and an AXI4-Lite master.
*/
// Overview of operation
// - latch address and command, assert reqn, status bit 0; bit 1 once granted
// - I/O and configuration reads are always single phase, last is ignored
// - after address phase float ad, assert irdyn; deassert framen only for a single phase
// - status bit 2 set on entering the data phase
// - irdyn asserted on the first data phase regardless of busy
// - data phase completes when irdyn and trdyn asserted, devseln claims
// - clock after completion present read word and assert local acknowledge
// - same clock set status bit 7 for one successful data phase
// - after single phase deassert irdyn and float command bus next clock
// - one clock later float irdyn and clear all status bits
// - acknowledge drops once the final word has been handed over
// - memory read, read multiple and read line handled identically
// - target wait in burst withdraws the local acknowledge next clock
// - local busy in the clock a data phase completes deasserts irdyn next clock and withholds acknowledge
// - wait states are propagated either way only when needed
// - after last at most two more data phases, one if irdyn dropped
// - one clock of last suffices; continued assertion is ignored
// - byte enables select bytes only in single-cycle transactions
package pmrs_pkg;
  // pci command codes
  localparam logic [3:0] CMD_IO_RD  = 4'h2;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_MRM    = 4'hc;
  localparam logic [3:0] CMD_MRL    = 4'he;
  localparam logic [3:0] BE_ALL_N   = 4'h0;
  // transaction status bits
  localparam int         TSR_REQ    = 0;
  localparam int         TSR_GNT    = 1;
  localparam int         TSR_XFER   = 2;
  localparam int         TSR_DONE   = 7;
  localparam logic [7:0] TSR_RST    = 8'h00;
  // register map
  localparam int         AXI_AW     = 4;
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STAT   = 4'h4;
  localparam logic [3:0] OFS_PHASE  = 4'h8;
  localparam int         CTRL_EN    = 0;
  localparam logic       CTRL_RST   = 1'b1;
  localparam int         STAT_ST_LSB = 8;
  localparam int         STAT_PEND  = 15;
  localparam int         CNT_W      = 16;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_REQ  = 6'h02,
    ST_DRV  = 6'h04,
    ST_ADR  = 6'h08,
    ST_DAT  = 6'h10,
    ST_TA1  = 6'h20
  } pmrs_state_e;
endpackage

// file: logic/pmrs_word_reg.sv
/*
  Loadable word register, used for the latched address and the read words.
  Assumes the single clock and the asynchronous active-low reset of the block.
*/
`timescale 1ns/1ps
module pmrs_word_reg #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // load port
  input  wire logic         load,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] word;
  } pmrs_word_s;

  pmrs_word_s r_r;
  pmrs_word_s r_nxt;

  always_comb begin
    r_nxt = r_r;
    if (load) begin
      r_nxt.word = d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.word;
endmodule

// file: verif/pmrs_master_read_checker.sv
/*
  Concurrent checks on the pins of the PCI master read sequencer.
  Assumes a bind to pmrs_master_read; nrst is asynchronous, active low.
*/
`timescale 1ns/1ps
module pmrs_master_read_checker
  import pmrs_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // local side
  input wire logic       local_last_transfer_n,
  input wire logic [3:0] local_cmd_byte_en_n,
  input wire logic       local_wait_request_n,
  input wire logic       local_data_ack_n,
  input wire logic [7:0] txn_status_out,
  // pci side
  input wire logic       reqn,
  input wire logic       ad_oe,
  input wire logic [3:0] cben_out,
  input wire logic       cben_oe,
  input wire logic       framen_out,
  input wire logic       framen_oe,
  input wire logic       irdyn_out,
  input wire logic       irdyn_oe,
  input wire logic       trdyn,
  input wire logic       devseln
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire done_c = !irdyn_out && irdyn_oe && !trdyn && !devseln;
  wire adr_c = ad_oe && framen_oe && !framen_out;
  sequence ack_s;
    !local_data_ack_n && txn_status_out[TSR_DONE];
  endsequence
  // turn-around: irdyn high then floated, status cleared
  sequence turn_s;
    irdyn_out && !cben_oe && !framen_oe
    ##1 !irdyn_oe && txn_status_out == TSR_RST && local_data_ack_n;
  endsequence
  reset_a: assert property (
    $rose(nrst) |-> txn_status_out == TSR_RST && local_data_ack_n && reqn
      && !ad_oe && !cben_oe && !framen_oe && !irdyn_oe)
    else $error("outputs not idle after reset");
  req_a: assert property (
    $fell(reqn) |-> txn_status_out == 8'h01)
    else $error("request status wrong");
  // single reads carry the local byte enables, bursts all bytes
  byte_en_a: assert property (
    adr_c |=> cben_out == (framen_out ? $past(local_cmd_byte_en_n) : BE_ALL_N))
    else $error("byte enables wrong in data phase");
  first_a: assert property (
    adr_c |=> !irdyn_out && irdyn_oe && !ad_oe && txn_status_out[TSR_XFER])
    else $error("first data phase wrong");
  single_a: assert property (
    adr_c && (!local_last_transfer_n || cben_out == CMD_IO_RD || cben_out == CMD_CFG_RD)
      |=> framen_out && framen_oe)
    else $error("single read not final");
  ack_a: assert property (
    done_c && local_wait_request_n |=> ack_s)
    else $error("missing ack after phase");
  twait_a: assert property (
    !irdyn_out && irdyn_oe && trdyn |=> local_data_ack_n)
    else $error("ack during target wait");
  busy_a: assert property (
    done_c && !local_wait_request_n |=> irdyn_out && local_data_ack_n)
    else $error("busy not propagated");
  last_a: assert property (
    !local_last_transfer_n && !irdyn_out && irdyn_oe && !framen_out && framen_oe
      |=> irdyn_out || framen_out)
    else $error("burst not ending after last");
  final_a: assert property (
    done_c && framen_out && local_wait_request_n |=> turn_s)
    else $error("bad turn-around");
endmodule

bind pmrs_master_read pmrs_master_read_checker u_pmrs_master_read_checker (
  .clk, .nrst, .local_last_transfer_n, .local_cmd_byte_en_n, .local_wait_request_n,
  .local_data_ack_n,
  .txn_status_out, .reqn, .ad_oe, .cben_out, .cben_oe, .framen_out, .framen_oe,
  .irdyn_out, .irdyn_oe, .trdyn, .devseln
);

// file: verif/pmrs_pci_target.sv
/*
  Behavioural PCI arbiter and target facing the master read sequencer.
  Assumes framen and irdyn pulled up; word k of a burst reads address + 4k.
*/
`timescale 1ns/1ps
module pmrs_pci_target (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // master pins
  input  wire logic        reqn,
  input  wire logic [31:0] ad_out,
  input  wire logic        framen_out,
  input  wire logic        framen_oe,
  input  wire logic        irdyn_out,
  input  wire logic        irdyn_oe,
  input  wire logic        tgt_wait,
  // target and arbiter pins
  output logic             gntn,
  output logic             trdyn,
  output logic             devseln,
  output logic [31:0]      ad_in,
  output logic             framen_in,
  output logic             irdyn_in,
  output logic [7:0]       phases
);
  logic        claim;
  logic [31:0] base;
  assign framen_in = framen_oe ? framen_out : 1'b1;
  assign irdyn_in  = irdyn_oe ? irdyn_out : 1'b1;
  assign devseln   = !claim;
  assign trdyn     = !(claim && !tgt_wait);
  // undriven data shows the complement so a stale word cannot pass
  assign ad_in     = (claim && !irdyn_in) ? base + {22'h0, phases, 2'h0} : ~base;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gntn   <= 1'b1;
      claim  <= 1'b0;
      base   <= 32'h0;
      phases <= 8'h0;
    end else begin
      // grant trails the request by one clock
      gntn <= reqn;
      if (!framen_in && !claim) begin
        claim  <= 1'b1;
        base   <= ad_out;
        phases <= 8'h0;
      end else if (claim && framen_in && irdyn_in) begin
        claim <= 1'b0;
      end
      if (claim && !irdyn_in && !trdyn) begin
        phases <= phases + 8'h1;
      end
    end
  end
endmodule

// file: verif/pci_master_read_sequencer_tb.sv
/*
  Self-checking bench: single and burst reads, waits, resets, registers.
  Assumes the target model and the bound checker.
*/
`timescale 1ns/1ps
module pci_master_read_sequencer_tb
  import pmrs_pkg::*;
;
  localparam logic [31:0] ADDR = 32'h0000_1a40;
  logic        clk = 1'b0, nrst = 1'b0, rq_n = 1'b1, last_n = 1'b1, busy_n = 1'b1;
  logic        tw = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic        s_arvalid = 1'b0, s_rready = 1'b0;
  logic [3:0]  cbe = 4'h0, s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf;
  logic [31:0] s_wdata = 32'h0, adi = 32'h0;
  logic        local_data_ack_n, reqn, gntn, ad_oe, cben_oe, framen_in, framen_out;
  logic        framen_oe, irdyn_in, irdyn_out, irdyn_oe, trdyn, devseln;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp;
  logic [3:0]  cben_out;
  logic [7:0]  txn_status_out, phases;
  logic [31:0] local_read_data_out, ad_in, ad_out, s_rdata;
  int          fail_count = 0, compares = 0, got = 0, cyc = 0, n;
  // command, last level, words expected
  logic [7:0]  rows [5] = '{{CMD_IO_RD, 1'b1, 3'h1}, {CMD_CFG_RD, 1'b1, 3'h1},
    {CMD_MEM_RD, 1'b0, 3'h1}, {CMD_MRM, 1'b0, 3'h1}, {CMD_MRL, 1'b0, 3'h1}};
  pmrs_master_read u_pmrs_master_read (
    .clk, .nrst, .local_master_request_n(rq_n), .local_addr_data_in(adi),
    .local_cmd_byte_en_n(cbe), .local_last_transfer_n(last_n),
    .local_wait_request_n(busy_n), .local_data_ack_n, .local_read_data_out,
    .txn_status_out, .reqn, .gntn, .ad_in, .ad_out, .ad_oe, .cben_out, .cben_oe,
    .framen_in, .framen_out, .framen_oe, .irdyn_in, .irdyn_out, .irdyn_oe, .trdyn,
    .devseln, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready
  );
  pmrs_pci_target u_pmrs_pci_target (
    .clk, .nrst, .reqn, .ad_out, .framen_out, .framen_oe, .irdyn_out, .irdyn_oe,
    .tgt_wait(tw), .gntn, .trdyn, .devseln, .ad_in, .framen_in, .irdyn_in, .phases
  );
  always #12.5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    compares++;
    if (a !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, a);
    end
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  always @(negedge clk) begin
    if (local_data_ack_n === 1'b0) begin
      chk("read word", ADDR + 32'(4 * got), local_read_data_out);
      got++;
    end
  end
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (s_awready !== 1'b1);
        s_awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (s_wready !== 1'b1);
        s_wvalid <= 1'b0;
      end
    join
    while (s_bvalid !== 1'b1) @(posedge clk);
    chk("bresp", 32'(r), 32'(s_bresp));
    s_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    while (s_rvalid !== 1'b1) @(posedge clk);
    chk("rdata", d, s_rdata);
    chk("rresp", 32'(r), 32'(s_rresp));
    s_rready <= 1'b0;
  endtask
  task automatic start(input logic [3:0] c, input logic l);
    got = 0;
    @(posedge clk);
    rq_n <= 1'b0;
    adi <= ADDR;
    cbe <= c;
    last_n <= l;
    @(posedge clk);
    rq_n <= 1'b1;
    // address moves on at once: only a latched copy reaches the bus
    adi <= ~ADDR;
    cbe <= l ? BE_ALL_N : 4'h3;
  endtask
  task automatic finish;
    do @(negedge clk); while (txn_status_out !== TSR_RST);
  endtask
  task automatic wait_got(input int k);
    do @(posedge clk); while (got < k);
  endtask
  task automatic idle_chk;
    chk("idle pins", 32'h21, 32'({txn_status_out, local_data_ack_n, ad_oe, cben_oe,
      framen_oe, irdyn_oe, reqn}));
    chk("read data", 32'h0, local_read_data_out);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    idle_chk();
    axi_rd(OFS_STAT, 32'h0000_0100, RESP_OKAY);
    axi_rd(4'hc, 32'h0, RESP_SLVERR);
    axi_wr(4'hc, 32'h0, RESP_SLVERR);
    axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
    @(posedge clk);
    rq_n <= 1'b0;
    repeat (4) @(posedge clk);
    rq_n <= 1'b1;
    @(negedge clk);
    chk("refused request", 32'h1, 32'({txn_status_out, reqn}));
    axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
    axi_rd(OFS_CTRL, 32'h1, RESP_OKAY);
    foreach (rows[i]) begin
      start(rows[i][7:4], rows[i][3]);
      finish();
      chk("single words", 32'(rows[i][2:0]), 32'(got));
      chk("single phases", 32'(rows[i][2:0]), 32'(phases));
    end
    // burst with a target wait, one local busy clock, then last held two clocks
    start(CMD_MEM_RD, 1'b1);
    wait_got(2);
    tw <= 1'b1;
    @(posedge clk);
    tw <= 1'b0;
    wait_got(4);
    busy_n <= 1'b0;
    @(posedge clk);
    busy_n <= 1'b1;
    wait_got(6);
    last_n <= 1'b0;
    @(negedge clk);
    n = int'(phases);
    repeat (2) @(posedge clk);
    last_n <= 1'b1;
    finish();
    chk("burst phases", 32'(n + 2), 32'(phases));
    chk("burst words", 32'(phases), 32'(got));
    // one phase per single row plus the burst, then clear; status ignores writes
    axi_rd(OFS_PHASE, 32'(phases) + 32'($size(rows)), RESP_OKAY);
    axi_wr(OFS_PHASE, 32'h0, RESP_OKAY);
    axi_wr(OFS_STAT, 32'hffff_ffff, RESP_OKAY);
    axi_rd(OFS_PHASE, 32'h0, RESP_OKAY);
    axi_rd(OFS_STAT, 32'h0000_0100, RESP_OKAY);
    // reset in mid-burst, then a fresh read
    start(CMD_MRL, 1'b1);
    wait_got(2);
    nrst <= 1'b0;
    @(negedge clk);
    idle_chk();
    @(posedge clk);
    nrst <= 1'b1;
    start(CMD_IO_RD, 1'b1);
    finish();
    chk("words after reset", 32'h1, 32'(got));
    tally_and_finish();
  end
endmodule
